// *** dv/soes_checker_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
module soes_checker (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // watched ports
   input wire logic serial_select_n,
   input wire logic measDone,
   input wire logic so,
   input wire logic soEn,
   input wire logic irq_n,
   input wire soes_pkg::soes_meas_ctl_type measCtl,
   input wire logic hitsEnabled
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   a_irq_sel_clear: assert property ($fell(serial_select_n) |-> ##[1:6] irq_n)
      else $error("irq not cleared by select");
   a_irq_holds: assert property (!irq_n && serial_select_n |=> !irq_n)
      else $error("irq dropped without select");
   a_idle_no_drive: assert property (serial_select_n [*4] |-> !soEn && !so)
      else $error("output driven while deselected");
   a_charge_after_osc: assert property ($rose(measCtl.capCharge) |-> $past(measCtl.hsOscOn))
      else $error("charge before oscillator");
   a_fire_after_chg: assert property ($rose(measCtl.fireGo) |-> $past(measCtl.capCharge))
      else $error("fire before charge");
   a_stop_after_fire: assert property ($rose(measCtl.stopOpen) |-> $past(measCtl.fireGo))
      else $error("stop opened before fire");
   a_done_irq: assert property (measCtl.stopOpen && measDone |=> !irq_n)
      else $error("no irq after flight");
   a_init_arms: assert property (measCtl.initGo |=> hitsEnabled && !measCtl.initGo)
      else $error("init did not arm hits");
   cover property ($rose(measCtl.stopOpen));
   cover property ($fell(irq_n));
   cover property ($rose(hitsEnabled));
endmodule
bind spi_opcode_eeprom_sequencer soes_checker i_soes_checker (.sys_clk, .rst_b,
   .serial_select_n, .measDone, .so, .soEn, .irq_n, .measCtl, .hitsEnabled);
`default_nettype wire

// *** dv/soes_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module soes_host (
   // serial link
   output logic serial_select_n,
   output logic sck,
   output logic si,
   input wire logic so
);
   // clock idles low outside frames
   initial begin
      serial_select_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
   end
   // change data on rise, take it on fall; msb first
   task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
      rx = '0;
      serial_select_n = 1'b0;
      #50;
      for (int i = 0; i < n; i++) begin
         sck = 1'b1;
         si = tx[39-i];
         #24 sck = 1'b0;
         rx = {rx[38:0], so};
         #24;
      end
      serial_select_n = 1'b1;
      si = ~si; // a released line keeps no stale value
      #60;
   endtask
endmodule
`default_nettype wire

// *** dv/spi_opcode_eeprom_sequencer_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module spi_opcode_eeprom_sequencer_tb_top;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic measDone = 1'b0;
   logic widthRatioValid = 1'b0;
   logic [7:0] widthRatio = 8'h00;
   logic [12:0] coreStatus = 13'h0000;
   logic serial_select_n, sck, si, so, soEn, irq_n, hitsEnabled;
   soes_pkg::soes_meas_ctl_type measCtl;
   logic [6:0][31:0] cfgOut;
   logic [39:0] rx;
   logic [31:0] lfsr = 32'h3770;
   logic [31:0] c1;
   logic hsClk = 1'b0;
   int errors = 0;
   int checks = 0;
   always #2.5 sys_clk = ~sys_clk;
   // oscillator of 20 ns period, four system cycles, so a calibration count is exact
   always #10 hsClk = ~hsClk;
   soes_host i_soes_host (.serial_select_n, .sck, .si, .so);
   spi_opcode_eeprom_sequencer #(.NV_OP_CYCLES(50), .HALF50_CYCLES(40), .HALF60_CYCLES(30),
      .CALRES_CYCLES(20)) i_spi_opcode_eeprom_sequencer (.sys_clk, .rst_b, .serial_select_n,
      .sck, .si, .so, .soEn, .irq_n, .measCtl, .hitsEnabled, .cfgOut, .measDone,
      .thermalDone(1'b0), .hs_clk(hsClk), .coreResult({3{lfsr}}), .coreStatus, .widthRatio,
      .widthRatioValid);
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // status word as the host should see it
   function automatic logic [39:0] stat(input logic eq, input logic [12:0] c);
      return {24'h00_0000, eq, 2'b00, c};
   endfunction
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // bounded wait on the interrupt
   task automatic wirq;
      for (int i = 0; i < 20000 && irq_n !== 1'b0; i++) @(posedge sys_clk);
      chk(irq_n, 1'b0);
   endtask
   task automatic op(input logic [7:0] c, input int n);
      i_soes_host.xfer({c, 32'h0000_0000}, n, rx);
   endtask
   // watchdog sized well past the expected run
   initial begin
      #200_000;
      errors++;
      end_sim();
   end
   // main sequence
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge sys_clk);
      op(soes_pkg::OP_INIT, 4);
      chk(hitsEnabled, 1'b0);
      op(soes_pkg::OP_INIT, 8);
      chk(hitsEnabled, 1'b1);
      for (int a = 1; a < 6; a += 2) begin
         lfsr = nxt(lfsr);
         i_soes_host.xfer({5'h10, a[2:0], lfsr}, 40, rx);
         chk(cfgOut[a], lfsr);
         c1 = (a == 1) ? lfsr : c1;
      end
      op(soes_pkg::OP_READ_HI << 3 | 8'h05, 16);
      chk(rx[7:0], c1[31:24]);
      i_soes_host.xfer({8'h86, 24'h00_2000, 8'h00}, 32, rx);
      chk(cfgOut[6], 32'h0020_0000);
      @(posedge sys_clk);
      widthRatio <= lfsr[7:0];
      widthRatioValid <= 1'b1;
      coreStatus <= lfsr[12:0];
      @(posedge sys_clk);
      widthRatioValid <= 1'b0;
      op(soes_pkg::OP_READ_RATIO, 16);
      chk(rx[7:0], lfsr[7:0]);
      op(soes_pkg::OP_NV_STORE, 8);
      wirq();
      for (int k = 1; k >= 0; k--) begin
         op(soes_pkg::OP_NV_COMPARE, 8);
         wirq();
         op(8'hB4, 24);
         chk(rx, stat(k[0], lfsr[12:0]));
         chk(irq_n, 1'b1);
         i_soes_host.xfer({8'h81, ~c1}, 40, rx);
      end
      op(soes_pkg::OP_NV_RECALL, 8);
      wirq();
      chk(cfgOut[1], c1);
      op(soes_pkg::OP_RESONATOR_CAL, 8);
      wirq();
      op(8'hB0, 40);
      chk(rx, 40'd20 / 40'd4);
      op(8'hB3, 40);
      chk(rx, lfsr);
      op(soes_pkg::OP_FLIGHT_MEASURE_CMD, 8);
      for (int i = 0; i < 20000 && measCtl.stopOpen !== 1'b1; i++) @(posedge sys_clk);
      measDone <= 1'b1;
      @(posedge sys_clk);
      measDone <= 1'b0;
      wirq();
      end_sim();
   end
endmodule
`default_nettype wire

// *** hdl/soes_pkg.sv ***
package soes_pkg;
   // opcodes
   localparam logic [4:0] OP_WRITE_HI = 5'h10;
   localparam logic [4:0] OP_READ_HI = 5'h16;
   localparam logic [7:0] OP_READ_ID = 8'hB7;
   localparam logic [7:0] OP_READ_RATIO = 8'hB8;
   localparam logic [7:0] OP_NV_STORE = 8'hC0;
   localparam logic [7:0] OP_NV_RECALL = 8'hF0;
   localparam logic [7:0] OP_NV_COMPARE = 8'hC6;
   localparam logic [7:0] OP_INIT = 8'h70;
   localparam logic [7:0] OP_POWER_ON_RESET = 8'h50;
   localparam logic [7:0] OP_FLIGHT_MEASURE_CMD = 8'h01;
   localparam logic [7:0] OP_THERMAL = 8'h02;
   localparam logic [7:0] OP_RESONATOR_CAL = 8'h03;
   localparam logic [7:0] OP_CONVERTER_CALIBRATE_CMD = 8'h04;
   localparam logic [7:0] OP_FLIGHT_UPDOWN_CMD = 8'h05;
   localparam logic [7:0] OP_THERMAL_UPDOWN = 8'h06;
   // read addresses
   localparam logic [2:0] RA_RESULT0 = 3'h0;
   localparam logic [2:0] RA_STATUS = 3'h4;
   localparam logic [2:0] RA_CFG1_TOP = 3'h5;
   localparam int NV_WORDS = 7;
   // status word bits
   localparam int ST_NV_SINGLE = 13;
   localparam int ST_NV_DOUBLE = 14;
   localparam int ST_NV_EQUAL = 15;
   // ratio format: 1 integer bit, 7 fraction bits
   localparam int RATIO_INT_BITS = 1;
   localparam int RATIO_FRAC_BITS = 7;
   // configuration fields: register index and low bit
   localparam int CF_SETTLE_REG = 0;
   localparam int CF_SETTLE_LO = 18;
   localparam int CF_CALWIN_REG = 0;
   localparam int CF_CALWIN_LO = 22;
   localparam int CF_DELAY_REG = 3;
   localparam int CF_CHARGE_LO = 24;
   localparam int CF_STOPOPEN_LO = 28;
   localparam int CF_SEQ_REG = 6;
   localparam int CF_FLIGHT_GAP_LO = 8;
   localparam int CF_THERMAL_GAP_LO = 10;
   localparam int CF_DUMMY_LO = 13;
   localparam int CF_MAINS60_BIT = 15;
   localparam int CF_PORT_REV_BIT = 16;
   localparam int CF_NV_IRQ_EN_BIT = 21;
   // timing
   localparam int CLK_MHZ = 200;
   localparam int NV_OP_MS = 130;
   localparam int NV_OP_CYC = NV_OP_MS * 1000 * CLK_MHZ;
   localparam int MAINS50_US = 20000;
   localparam int MAINS60_US = 16670;
   localparam int HALF50_CYC = MAINS50_US * CLK_MHZ / 2;
   localparam int HALF60_CYC = MAINS60_US * CLK_MHZ / 2;
   localparam int CALRES_BASE_US = 61;
   localparam int CALRES_CYC = CALRES_BASE_US * CLK_MHZ;
   localparam int DELAY_UNIT_US = 1;
   localparam int DELAY_UNIT_CYC = DELAY_UNIT_US * CLK_MHZ;
   // controls towards the measurement core
   typedef struct packed {
      logic hsOscOn;
      logic analogOn;
      logic capCharge;
      logic fireGo;
      logic stopOpen;
      logic thermalGo;
      logic [1:0] thermalPort;
      logic convCalGo;
      logic initGo;
   } soes_meas_ctl_type;
   // sequencer states
   typedef enum logic [9:0] {
      ST_IDLE = 10'h001,
      ST_SETTLE = 10'h002,
      ST_CHARGE = 10'h004,
      ST_FIRE = 10'h008,
      ST_MEAS = 10'h010,
      ST_GAP = 10'h020,
      ST_THERMAL = 10'h040,
      ST_CALRES = 10'h080,
      ST_CALCONV = 10'h100,
      ST_NV = 10'h200
   } soes_state_type;
endpackage

// *** hdl/spi_opcode_eeprom_sequencer.sv ***
// Behaviour
// [R1] ratio register: unsigned 1.7 fixed point
// [R2] seven-word nonvolatile store, three actions only
// [R3] host stores only while idle
// [R4] only identification bytes read back
// [R5] Hamming code: correct single, flag double
// [R6] read/compare single error triggers refresh
// [R7] clock idles low, sample falling edge
// [R8] select fall or first clock rise clears irq
// [R9] select high resets serial interface
// [R10] host holds select high 50 ns
// [R11] write/read opcode plus 3-bit address
// [R12] config writes: three bytes legacy, four full
// [R13] decode store, recall, compare opcodes
// [R14] bytewise, MSB first, select ends transfer
// [R15] nonvolatile end raises enabled interrupt
// [R16] flight sequence steps then interrupt
// [R17] up/down flight runs twice, two interrupts
// [R18] gap is factor times mains period
// [R19] thermal dummies then ports, optional reversed
// [R20] thermal restart runs twice with own gap
// [R21] resonator calibration count into result zero
// [R22] converter calibration opcode
// [R23] status bits 13, 14, 15 nonvolatile flags
// [R24] hits accepted only after init
// [R25] act only on complete command byte
`timescale 1ns/10ps
`default_nettype none
module spi_opcode_eeprom_sequencer #(
   parameter int NV_OP_CYCLES = soes_pkg::NV_OP_CYC,
   parameter int HALF50_CYCLES = soes_pkg::HALF50_CYC,
   parameter int HALF60_CYCLES = soes_pkg::HALF60_CYC,
   parameter int CALRES_CYCLES = soes_pkg::CALRES_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // serial link
   input wire logic serial_select_n,
   input wire logic sck,
   input wire logic si,
   output logic so,
   output logic soEn,
   output logic irq_n,
   // measurement core
   output soes_pkg::soes_meas_ctl_type measCtl,
   output logic hitsEnabled,
   output logic [6:0][31:0] cfgOut,
   input wire logic measDone,
   input wire logic thermalDone,
   input wire logic hs_clk,
   input wire logic [2:0][31:0] coreResult,
   input wire logic [12:0] coreStatus,
   input wire logic [7:0] widthRatio,
   input wire logic widthRatioValid
);
   logic [2:0] sckS_reg, ssnS_reg, siS_reg, hsS_reg;
   logic [7:0] rxShift_reg, opcode_reg, first_wave_width_ratio_reg;
   logic [2:0] bitCnt_reg, byteCnt_reg, step_reg;
   logic [31:0] wrData_reg, cnt_reg, calCnt_reg, result0_reg;
   logic [63:0] txShift_reg, rdVal;
   logic so_reg, irq_reg, armed_reg, pass_reg, restart_reg, isThermal_reg;
   logic nv_matches_config_flag_reg, nv_uncorrectable_error_flag_reg;
   logic nvSingle_reg;
   logic [31:0] cfg_reg [7];
   logic [38:0] nvMem_reg [7];
   logic [6:0][31:0] decData;
   logic [6:0] decSingle, decDouble, wordEq;
   logic [55:0] idBits;
   logic [15:0] status;
   logic [7:0] newByte;
   logic sckRise, sckFall, ssnHigh, ssnFall, ssnRise, byteDone, cmdPulse;
   logic idle, cntZero, seqDone, nvDone, lastStep;
   logic nvStoreDo, nvRecallDo, nvCompareDo, porDo;
   logic [1:0] thermalIdx;
   soes_pkg::soes_state_type state_reg;

   // Hamming encode: data at non power-of-two positions, overall parity in bit 0
   function automatic logic [38:0] eccEncode(input logic [31:0] d);
      logic [38:0] c;
      logic [5:0] s;
      int k;
      c = '0;
      s = '0;
      k = 0;
      for (int i = 1; i < 39; i++) begin
         if ((i & (i - 1)) != 0) begin
            c[i] = d[k];
            k++;
         end
      end
      for (int i = 1; i < 39; i++) begin
         if (c[i]) begin
            s = s ^ 6'(i);
         end
      end
      for (int j = 0; j < 6; j++) begin
         c[1 << j] = s[j];
      end
      c[0] = ^c[38:1];
      return c;
   endfunction

   // decode returns {double, single, corrected data}
   function automatic logic [33:0] eccDecode(input logic [38:0] cw);
      logic [38:0] c;
      logic [31:0] d;
      logic [5:0] s;
      logic p, ok;
      int k;
      c = cw;
      d = '0;
      s = '0;
      k = 0;
      for (int i = 1; i < 39; i++) begin
         if (c[i]) begin
            s = s ^ 6'(i);
         end
      end
      p = ^c;
      ok = s < 6'd39;
      if (p && ok) begin
         c[s] = ~c[s];
      end
      for (int i = 1; i < 39; i++) begin
         if ((i & (i - 1)) != 0) begin
            d[k] = c[i];
            k++;
         end
      end
      return {((s != 6'd0) && !p) || (p && !ok), p && ok, d};
   endfunction

   // mains gap: half periods times (2 + field) gives factors 1, 1.5, 2, 2.5
   function automatic logic [31:0] gapCycles(input logic [1:0] f, input logic sixty);
      logic [31:0] half;
      half = sixty ? 32'(HALF60_CYCLES) : 32'(HALF50_CYCLES);
      return 32'(half * (32'(f) + 32'd2));
   endfunction

   // two-stage synchronisers; edges come from stages 1 and 2 only
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sckS_reg <= 3'h0;
         ssnS_reg <= 3'h7;
         siS_reg <= 3'h0;
         hsS_reg <= 3'h0;
      end else begin
         sckS_reg <= {sckS_reg[1:0], sck};
         ssnS_reg <= {ssnS_reg[1:0], serial_select_n};
         siS_reg <= {siS_reg[1:0], si};
         hsS_reg <= {hsS_reg[1:0], hs_clk};
      end
   end

   assign sckRise = sckS_reg[1] & ~sckS_reg[2];
   assign sckFall = ~sckS_reg[1] & sckS_reg[2]; // [R7]
   assign ssnHigh = ssnS_reg[1];
   assign ssnFall = ~ssnS_reg[1] & ssnS_reg[2];
   assign ssnRise = ssnS_reg[1] & ~ssnS_reg[2];
   assign newByte = {rxShift_reg[6:0], siS_reg[1]}; // [R14]
   assign byteDone = sckFall & ~ssnHigh & (bitCnt_reg == 3'h7);
   assign cmdPulse = byteDone & (byteCnt_reg == 3'h0); // [R25]
   assign idle = state_reg == soes_pkg::ST_IDLE;
   assign cntZero = cnt_reg == 32'h0000_0000;
   // nonvolatile actions only start from idle, so a store never overlaps a run
   assign nvStoreDo = cmdPulse & idle & (newByte == soes_pkg::OP_NV_STORE); // [R13] [R3]
   assign nvRecallDo = cmdPulse & idle & (newByte == soes_pkg::OP_NV_RECALL); // [R13]
   assign nvCompareDo = cmdPulse & idle & (newByte == soes_pkg::OP_NV_COMPARE); // [R13]
   assign porDo = cmdPulse & (newByte == soes_pkg::OP_POWER_ON_RESET);

   // receive: select high clears the bit and byte position
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rxShift_reg <= 8'h00;
         bitCnt_reg <= 3'h0;
         byteCnt_reg <= 3'h0;
         opcode_reg <= 8'h00;
         wrData_reg <= 32'h0000_0000;
      end else if (ssnHigh) begin
         bitCnt_reg <= 3'h0; // [R9]
         byteCnt_reg <= 3'h0; // [R9]
      end else if (sckFall) begin
         rxShift_reg <= newByte;
         bitCnt_reg <= bitCnt_reg + 3'h1;
         if (bitCnt_reg == 3'h7) begin
            byteCnt_reg <= byteCnt_reg + {2'h0, byteCnt_reg != 3'h7};
            if (byteCnt_reg == 3'h0) begin
               opcode_reg <= newByte;
            end else begin
               wrData_reg <= {wrData_reg[23:0], newByte};
            end
         end
      end
   end

   assign status = {nv_matches_config_flag_reg, nv_uncorrectable_error_flag_reg,
                    nvSingle_reg, coreStatus}; // [R23]

   // read data, left aligned so it leaves MSB first
   always_comb begin
      rdVal = 64'h0000_0000_0000_0000;
      if (newByte == soes_pkg::OP_READ_ID) begin
         rdVal = {idBits, 8'h00}; // [R4]
      end else if (newByte == soes_pkg::OP_READ_RATIO) begin
         rdVal = {first_wave_width_ratio_reg, 56'h0}; // [R1]
      end else if (newByte[7:3] == soes_pkg::OP_READ_HI) begin
         case (newByte[2:0])
            soes_pkg::RA_RESULT0: rdVal = {result0_reg, 32'h0000_0000};
            3'h1, 3'h2, 3'h3: rdVal = {coreResult[newByte[1:0] - 2'h1], 32'h0000_0000};
            soes_pkg::RA_STATUS: rdVal = {status, 48'h0};
            soes_pkg::RA_CFG1_TOP: rdVal = {cfg_reg[1][31:24], 56'h0}; // [R11]
            default: rdVal = 64'h0000_0000_0000_0000;
         endcase
      end
   end

   // transmit: new bit on rising clock, host samples on falling
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         txShift_reg <= 64'h0000_0000_0000_0000;
         so_reg <= 1'b0;
      end else if (ssnHigh) begin
         txShift_reg <= 64'h0000_0000_0000_0000;
         so_reg <= 1'b0;
      end else if (cmdPulse) begin
         txShift_reg <= rdVal;
      end else if (sckRise) begin
         so_reg <= txShift_reg[63]; // [R7] [R14]
         txShift_reg <= {txShift_reg[62:0], 1'b0};
      end
   end

   assign so = so_reg;
   assign soEn = ~ssnHigh;

   // configuration registers; a write commits when select rises
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int w = 0; w < soes_pkg::NV_WORDS; w++) begin
            cfg_reg[w] <= 32'h0000_0000;
         end
      end else if (porDo) begin
         for (int w = 0; w < soes_pkg::NV_WORDS; w++) begin
            cfg_reg[w] <= 32'h0000_0000;
         end
      end else if (nvRecallDo) begin
         for (int w = 0; w < soes_pkg::NV_WORDS; w++) begin
            cfg_reg[w] <= decData[w]; // [R2]
         end
      end else if (ssnRise && opcode_reg[7:3] == soes_pkg::OP_WRITE_HI
                   && opcode_reg[2:0] != 3'h7) begin
         if (byteCnt_reg == 3'h4) begin
            cfg_reg[opcode_reg[2:0]][31:8] <= wrData_reg[23:0]; // [R11] [R12]
         end else if (byteCnt_reg == 3'h5) begin
            cfg_reg[opcode_reg[2:0]] <= wrData_reg; // [R12]
         end
      end
   end

   // decoded view of every stored word
   for (genvar w = 0; w < soes_pkg::NV_WORDS; w++) begin : gDec
      assign {decDouble[w], decSingle[w], decData[w]} = eccDecode(nvMem_reg[w]); // [R5]
      assign idBits[55 - 8 * w -: 8] = decData[w][7:0];
      assign wordEq[w] = decData[w] == cfg_reg[w];
      assign cfgOut[w] = cfg_reg[w];
   end

   // nonvolatile array: store, or refresh a word that held one error
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int w = 0; w < soes_pkg::NV_WORDS; w++) begin
            nvMem_reg[w] <= 39'h0;
         end
      end else begin
         for (int w = 0; w < soes_pkg::NV_WORDS; w++) begin
            if (nvStoreDo) begin
               nvMem_reg[w] <= eccEncode(cfg_reg[w]); // [R2]
            end else if ((nvRecallDo || nvCompareDo) && decSingle[w]) begin
               nvMem_reg[w] <= eccEncode(decData[w]); // [R6]
            end
         end
      end
   end

   // error flags refreshed by each recall or compare, the compare flag by each compare only
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         nvSingle_reg <= 1'b0;
         nv_uncorrectable_error_flag_reg <= 1'b0;
         nv_matches_config_flag_reg <= 1'b0;
      end else if (nvRecallDo || nvCompareDo) begin
         nvSingle_reg <= |decSingle; // [R5] [R6]
         nv_uncorrectable_error_flag_reg <= |decDouble; // [R5]
         if (nvCompareDo) begin
            nv_matches_config_flag_reg <= &wordEq; // [R23]
         end
      end
   end

   // ratio from the first-wave unit
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         first_wave_width_ratio_reg <= 8'h00;
      end else if (widthRatioValid) begin
         first_wave_width_ratio_reg <= widthRatio; // [R1]
      end
   end

   assign lastStep = {1'b0, step_reg} ==
                     {2'h0, cfg_reg[soes_pkg::CF_SEQ_REG][soes_pkg::CF_DUMMY_LO +: 2]} + 4'h3;
   assign thermalIdx = (step_reg < {1'b0, cfg_reg[soes_pkg::CF_SEQ_REG][soes_pkg::CF_DUMMY_LO +: 2]})
                       ? 2'h0
                       : 2'(step_reg - {1'b0, cfg_reg[soes_pkg::CF_SEQ_REG][soes_pkg::CF_DUMMY_LO +: 2]});
   assign seqDone = (state_reg == soes_pkg::ST_MEAS && measDone)
                    || (state_reg == soes_pkg::ST_THERMAL && thermalDone && lastStep)
                    || (state_reg == soes_pkg::ST_CALRES && cntZero)
                    || (state_reg == soes_pkg::ST_CALCONV && measDone);
   assign nvDone = state_reg == soes_pkg::ST_NV && cntZero;

   // measurement and nonvolatile sequencer
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= soes_pkg::ST_IDLE;
         cnt_reg <= 32'h0000_0000;
         pass_reg <= 1'b0;
         restart_reg <= 1'b0;
         isThermal_reg <= 1'b0;
         step_reg <= 3'h0;
         calCnt_reg <= 32'h0000_0000;
         result0_reg <= 32'h0000_0000;
      end else if (porDo) begin
         state_reg <= soes_pkg::ST_IDLE;
      end else begin
         if (!cntZero) begin
            cnt_reg <= cnt_reg - 32'h0000_0001;
         end
         case (state_reg)
            soes_pkg::ST_IDLE: begin
               pass_reg <= 1'b0;
               step_reg <= 3'h0;
               calCnt_reg <= 32'h0000_0000;
               if (cmdPulse) begin
                  case (newByte)
                     soes_pkg::OP_FLIGHT_MEASURE_CMD, soes_pkg::OP_FLIGHT_UPDOWN_CMD: begin
                        state_reg <= soes_pkg::ST_SETTLE; // [R16]
                        cnt_reg <= 32'(cfg_reg[soes_pkg::CF_SETTLE_REG][soes_pkg::CF_SETTLE_LO +: 2])
                                   * 32'(soes_pkg::DELAY_UNIT_CYC);
                        restart_reg <= newByte == soes_pkg::OP_FLIGHT_UPDOWN_CMD; // [R17]
                        isThermal_reg <= 1'b0;
                     end
                     soes_pkg::OP_THERMAL, soes_pkg::OP_THERMAL_UPDOWN: begin
                        state_reg <= soes_pkg::ST_THERMAL; // [R19]
                        restart_reg <= newByte == soes_pkg::OP_THERMAL_UPDOWN; // [R20]
                        isThermal_reg <= 1'b1;
                     end
                     soes_pkg::OP_RESONATOR_CAL: begin
                        state_reg <= soes_pkg::ST_CALRES; // [R21]
                        cnt_reg <= 32'(CALRES_CYCLES)
                                   << cfg_reg[soes_pkg::CF_CALWIN_REG][soes_pkg::CF_CALWIN_LO +: 2];
                     end
                     soes_pkg::OP_CONVERTER_CALIBRATE_CMD: state_reg <= soes_pkg::ST_CALCONV; // [R22]
                     soes_pkg::OP_NV_STORE, soes_pkg::OP_NV_RECALL, soes_pkg::OP_NV_COMPARE: begin
                        state_reg <= soes_pkg::ST_NV; // [R15]
                        cnt_reg <= 32'(NV_OP_CYCLES);
                     end
                     default: ;
                  endcase
               end
            end
            soes_pkg::ST_SETTLE: if (cntZero) begin
               state_reg <= soes_pkg::ST_CHARGE; // [R16]
               cnt_reg <= 32'(cfg_reg[soes_pkg::CF_DELAY_REG][soes_pkg::CF_CHARGE_LO +: 4])
                          * 32'(soes_pkg::DELAY_UNIT_CYC);
            end
            soes_pkg::ST_CHARGE: if (cntZero) begin
               state_reg <= soes_pkg::ST_FIRE; // [R16]
               cnt_reg <= 32'(cfg_reg[soes_pkg::CF_DELAY_REG][soes_pkg::CF_STOPOPEN_LO +: 4])
                          * 32'(soes_pkg::DELAY_UNIT_CYC);
            end
            soes_pkg::ST_FIRE: if (cntZero) begin
               state_reg <= soes_pkg::ST_MEAS; // [R16]
            end
            soes_pkg::ST_MEAS, soes_pkg::ST_THERMAL: if (seqDone) begin
               // second run follows after the mains gap
               if (restart_reg && !pass_reg) begin
                  state_reg <= soes_pkg::ST_GAP; // [R17] [R20]
                  pass_reg <= 1'b1;
                  cnt_reg <= gapCycles(isThermal_reg
                     ? cfg_reg[soes_pkg::CF_SEQ_REG][soes_pkg::CF_THERMAL_GAP_LO +: 2]
                     : cfg_reg[soes_pkg::CF_SEQ_REG][soes_pkg::CF_FLIGHT_GAP_LO +: 2],
                     cfg_reg[soes_pkg::CF_SEQ_REG][soes_pkg::CF_MAINS60_BIT]); // [R18] [R20]
               end else begin
                  state_reg <= soes_pkg::ST_IDLE;
               end
            end else if (state_reg == soes_pkg::ST_THERMAL && thermalDone) begin
               step_reg <= step_reg + 3'h1; // [R19]
            end
            soes_pkg::ST_GAP: if (cntZero) begin
               state_reg <= isThermal_reg ? soes_pkg::ST_THERMAL : soes_pkg::ST_SETTLE;
               step_reg <= 3'h0;
               cnt_reg <= 32'(cfg_reg[soes_pkg::CF_SETTLE_REG][soes_pkg::CF_SETTLE_LO +: 2])
                          * 32'(soes_pkg::DELAY_UNIT_CYC);
            end
            soes_pkg::ST_CALRES: begin
               if (hsRiseNow()) begin
                  calCnt_reg <= calCnt_reg + 32'h0000_0001; // [R21]
               end
               if (cntZero) begin
                  result0_reg <= calCnt_reg; // [R21]
                  state_reg <= soes_pkg::ST_IDLE;
               end
            end
            soes_pkg::ST_CALCONV: if (measDone) begin
               state_reg <= soes_pkg::ST_IDLE; // [R22]
            end
            soes_pkg::ST_NV: if (cntZero) begin
               state_reg <= soes_pkg::ST_IDLE;
            end
            default: state_reg <= soes_pkg::ST_IDLE;
         endcase
      end
   end

   function automatic logic hsRiseNow();
      return hsS_reg[1] & ~hsS_reg[2];
   endfunction

   // interrupt: a completion in the clearing cycle still sets it
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_reg <= 1'b0;
      end else if (seqDone || (nvDone && cfg_reg[soes_pkg::CF_SEQ_REG][soes_pkg::CF_NV_IRQ_EN_BIT])) begin
         irq_reg <= 1'b1; // [R15] [R16] [R17] [R21]
      end else if (ssnFall || (sckRise && !ssnHigh)) begin
         irq_reg <= 1'b0; // [R8]
      end
   end

   // hit acceptance armed by init, dropped by power-on reset
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         armed_reg <= 1'b0;
      end else if (porDo) begin
         armed_reg <= 1'b0;
      end else if (cmdPulse && newByte == soes_pkg::OP_INIT) begin
         armed_reg <= 1'b1; // [R24]
      end
   end

   assign irq_n = ~irq_reg;
   assign hitsEnabled = armed_reg;

   // core controls decoded from the state, the init pulse from the command byte
   always_comb begin
      measCtl = '0;
      measCtl.hsOscOn = (state_reg != soes_pkg::ST_IDLE) && (state_reg != soes_pkg::ST_NV)
                        && (state_reg != soes_pkg::ST_GAP); // [R16]
      measCtl.analogOn = state_reg == soes_pkg::ST_CHARGE || state_reg == soes_pkg::ST_FIRE
                         || state_reg == soes_pkg::ST_MEAS;
      measCtl.capCharge = state_reg == soes_pkg::ST_CHARGE;
      measCtl.fireGo = state_reg == soes_pkg::ST_FIRE;
      measCtl.stopOpen = state_reg == soes_pkg::ST_MEAS;
      measCtl.thermalGo = state_reg == soes_pkg::ST_THERMAL;
      measCtl.thermalPort = cfg_reg[soes_pkg::CF_SEQ_REG][soes_pkg::CF_PORT_REV_BIT]
                            ? 2'h3 - thermalIdx : thermalIdx; // [R19]
      measCtl.convCalGo = state_reg == soes_pkg::ST_CALCONV;
      measCtl.initGo = cmdPulse && newByte == soes_pkg::OP_INIT;
   end
endmodule
`default_nettype wire
